// File: hw/vector_address_map.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module vector_address_map
    import vector_map_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources
    input wire periph_req_t periph_req,
    input wire logic interrupt_enable,
    input wire logic instr_req,
    input wire logic instr_is_break,
    input wire logic [5:0] instr_number,
    // Sequencer side
    output vector_out_t vector_out
);

    logic [31:0] vector_table_base;
    logic [7:0] interrupt_source_select;
    logic bus_event_vector40_select;
    logic bus_event_vector41_select;
    logic [VEC_COUNT-1:0] req_map;
    logic periph_pending;
    logic [5:0] periph_number;
    logic [5:0] next_number;
    logic next_valid;
    logic next_instr;
    logic apb_write;
    logic apb_read;
    logic addr_hit;

    // Entry address: base plus four bytes per number, so the low byte
    // sits at the lowest address and the whole table covers 256 bytes
    function automatic logic [31:0] entry_address(input logic [31:0] base,
                                                  input logic [5:0] num);
        logic [7:0] ofs;
        ofs = {num, 2'b00};
        entry_address = base + {24'h00_0000, ofs};
    endfunction

    // Lowest pending number wins; priority levels live in the sequencer
    function automatic logic [5:0] first_set(input logic [VEC_COUNT-1:0] v);
        first_set = 6'h00;
        for (int i = VEC_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 6'(i);
            end
        end
    endfunction

    assign bus_event_vector40_select = interrupt_source_select[SEL_VEC40_BIT];
    assign bus_event_vector41_select = interrupt_source_select[SEL_VEC41_BIT];

    // Spread the request lines onto their table numbers
    always_comb begin
        req_map = '0;
        for (int i = 0; i < 4; i++) begin
            req_map[NUM_DMA0 + 6'(i)] = periph_req.dma_done[i];
        end
        for (int i = 0; i < 5; i++) begin
            req_map[NUM_FIRST_GROUP_TIMER_0 + 6'(i)] =
                periph_req.first_group_timer[i];
            req_map[NUM_SECOND_GROUP_TIMER_0 + 6'(i)] =
                periph_req.second_group_timer[i];
            req_map[NUM_PIO0 + 6'(i)] = periph_req.pio_unit[i];
        end
        req_map[NUM_SERIAL0_TX] = periph_req.serial_tx_nack[0];
        req_map[NUM_SERIAL0_RX] = periph_req.serial_rx_ack[0];
        req_map[NUM_SERIAL1_TX] = periph_req.serial_tx_nack[1];
        req_map[NUM_SERIAL1_RX] = periph_req.serial_rx_ack[1];
        // Pins run downward: pin 5 gets the lowest number
        for (int i = 0; i < 6; i++) begin
            req_map[NUM_EXT_PIN5 + 6'(i)] =
                periph_req.external_interrupt_pin[5 - i];
        end
        req_map[NUM_TIMER_B5] = periph_req.second_group_timer[5];
        for (int i = 0; i < 3; i++) begin
            req_map[NUM_SERIAL2_TX + 6'(2 * i)] =
                periph_req.serial_tx_nack[2 + i];
            req_map[NUM_SERIAL2_TX + 6'(2 * i + 1)] =
                periph_req.serial_rx_ack[2 + i];
        end
        req_map[NUM_BUS_EVENT2] = periph_req.serial_bus_event[2];
        // Shared vectors: a one selects the low channel of each pair
        req_map[NUM_BUS_EVENT40] = bus_event_vector40_select ?
            periph_req.serial_bus_event[0] :
            periph_req.serial_bus_event[3];
        req_map[NUM_BUS_EVENT41] = bus_event_vector41_select ?
            periph_req.serial_bus_event[1] :
            periph_req.serial_bus_event[4];
        req_map[NUM_ANALOG0] = periph_req.analog_converter_0;
        req_map[NUM_KEY_INPUT] = periph_req.key_input;
    end

    assign periph_pending = interrupt_enable && (req_map != '0);
    assign periph_number = first_set(req_map);

    // Instructions bypass the enable flag and beat peripheral requests
    always_comb begin
        next_valid = 1'b0;
        next_instr = 1'b0;
        next_number = periph_number;
        if (instr_req) begin
            next_valid = 1'b1;
            next_instr = 1'b1;
            if (instr_is_break) begin
                next_number = NUM_BREAK;
            end else begin
                next_number = instr_number;
            end
        end else if (periph_pending) begin
            next_valid = 1'b1;
        end
    end

    // Vector register toward the sequencer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_out <= '0;
        end else begin
            vector_out.valid <= next_valid;
            if (next_valid) begin
                vector_out.from_instruction <= next_instr;
                vector_out.number <= next_number;
                vector_out.address <=
                    entry_address(vector_table_base, next_number);
            end
        end
    end

    // APB decode; zero wait states
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && !pwrite;
    assign addr_hit = (paddr == OFS_TABLE_BASE) ||
                      (paddr == OFS_SOURCE_SEL) ||
                      (paddr == OFS_STATUS) ||
                      (paddr == OFS_LAST_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    // Base register; an odd base works but slows the sequence
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_table_base <= TABLE_BASE_RESET;
        end else if (apb_write && paddr == OFS_TABLE_BASE) begin
            vector_table_base <= pwdata;
        end
    end

    // Source select register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interrupt_source_select <= SOURCE_SEL_RESET;
        end else if (apb_write && paddr == OFS_SOURCE_SEL) begin
            interrupt_source_select <= pwdata[7:0];
        end
    end

    // Read data is registered during the setup cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (apb_read && !penable) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                OFS_TABLE_BASE: begin
                    prdata <= vector_table_base;
                end
                OFS_SOURCE_SEL: begin
                    prdata[7:0] <= interrupt_source_select;
                end
                OFS_STATUS: begin
                    prdata[ST_NUM_LSB +: NUM_W] <= vector_out.number;
                    prdata[ST_VALID_BIT] <= vector_out.valid;
                    prdata[ST_INSTR_BIT] <= vector_out.from_instruction;
                    prdata[ST_ODD_BASE_BIT] <= vector_table_base[0];
                end
                OFS_LAST_ADDR: begin
                    prdata <= vector_out.address;
                end
                default: begin
                    prdata <= 32'h0000_0000;
                end
            endcase
        end
    end

endmodule

// File: pkg/vector_map_pkg.sv
package vector_map_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_TABLE_BASE = 8'h00;
    localparam logic [7:0] OFS_SOURCE_SEL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_LAST_ADDR = 8'h0C;

    // Reset values
    localparam logic [31:0] TABLE_BASE_RESET = 32'h0000_0000;
    localparam logic [7:0] SOURCE_SEL_RESET = 8'h00;

    // Field positions in the select register
    localparam int SEL_VEC40_BIT = 6;
    localparam int SEL_VEC41_BIT = 7;

    // Status register field positions
    localparam int ST_NUM_LSB = 0;
    localparam int ST_VALID_BIT = 8;
    localparam int ST_INSTR_BIT = 9;
    localparam int ST_ODD_BASE_BIT = 10;

    // Table geometry
    localparam int NUM_W = 6;
    localparam int VEC_COUNT = 64;
    localparam int ENTRY_SHIFT = 2;

    // Software interrupt numbers
    localparam logic [5:0] NUM_BREAK = 6'h00;
    localparam logic [5:0] NUM_DMA0 = 6'h08;
    localparam logic [5:0] NUM_FIRST_GROUP_TIMER_0 = 6'h0C;
    localparam logic [5:0] NUM_SERIAL0_TX = 6'h11;
    localparam logic [5:0] NUM_SERIAL0_RX = 6'h12;
    localparam logic [5:0] NUM_SERIAL1_TX = 6'h13;
    localparam logic [5:0] NUM_SERIAL1_RX = 6'h14;
    localparam logic [5:0] NUM_SECOND_GROUP_TIMER_0 = 6'h15;
    localparam logic [5:0] NUM_EXT_PIN5 = 6'h1A;
    localparam logic [5:0] NUM_TIMER_B5 = 6'h20;
    localparam logic [5:0] NUM_SERIAL2_TX = 6'h21;
    localparam logic [5:0] NUM_BUS_EVENT2 = 6'h27;
    localparam logic [5:0] NUM_BUS_EVENT40 = 6'h28;
    localparam logic [5:0] NUM_BUS_EVENT41 = 6'h29;
    localparam logic [5:0] NUM_ANALOG0 = 6'h2A;
    localparam logic [5:0] NUM_KEY_INPUT = 6'h2B;
    localparam logic [5:0] NUM_PIO0 = 6'h2C;

    // Peripheral request lines, all active high levels
    typedef struct packed {
        logic [3:0] dma_done;
        logic [4:0] first_group_timer;
        logic [4:0] serial_tx_nack;
        logic [4:0] serial_rx_ack;
        logic [5:0] second_group_timer;
        logic [5:0] external_interrupt_pin;
        logic [4:0] serial_bus_event;
        logic analog_converter_0;
        logic key_input;
        logic [4:0] pio_unit;
    } periph_req_t;

    // Vector presented to the interrupt sequencer
    typedef struct packed {
        logic valid;
        logic from_instruction;
        logic [5:0] number;
        logic [31:0] address;
    } vector_out_t;

endpackage

// File: verif/vector_address_map_tb_top.sv
`timescale 1ns/1ps
module vector_address_map_tb_top
    import vector_map_pkg::*;
;
    logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00, sel = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, base = 32'h0000_0000, rd, prdata;
    logic pready, pslverr, err;
    logic interrupt_enable = 0, instr_req = 0, instr_is_break = 0;
    logic [5:0] instr_number = 6'h00;
    periph_req_t periph_req = '0;
    vector_out_t vector_out;
    logic [31:0] fetch_hi;
    int error_cnt = 0, total_checks = 0, cycles = 0;
    vector_address_map uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .periph_req, .interrupt_enable,
        .instr_req, .instr_is_break, .instr_number, .vector_out);
    vector_fetch_model partner (.vector_out, .fetch_hi);
    initial forever #25 sys_clk = ~sys_clk;
    // Hang guard, far above the roughly 1100 cycles of the run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reference: lowest mapped number among the requests, or -1
    function int ref_num(periph_req_t r, logic [7:0] s);
        logic [63:0] h;
        h = '0;
        for (int i = 0; i < 4; i++) h[8+i] = r.dma_done[i];
        for (int i = 0; i < 5; i++) begin
            h[12+i] = r.first_group_timer[i];
            h[21+i] = r.second_group_timer[i];
            h[44+i] = r.pio_unit[i];
            h[17+2*i] = i < 2 ? r.serial_tx_nack[i] : h[17+2*i];
            h[18+2*i] = i < 2 ? r.serial_rx_ack[i] : h[18+2*i];
            h[29+2*i] = i > 1 ? r.serial_tx_nack[i] : h[29+2*i];
            h[30+2*i] = i > 1 ? r.serial_rx_ack[i] : h[30+2*i];
        end
        for (int i = 0; i < 6; i++) h[31-i] = r.external_interrupt_pin[i];
        h[32] = r.second_group_timer[5];
        h[39] = r.serial_bus_event[2];
        h[40] = s[6] ? r.serial_bus_event[0] : r.serial_bus_event[3];
        h[41] = s[7] ? r.serial_bus_event[1] : r.serial_bus_event[4];
        h[42] = r.analog_converter_0;
        h[43] = r.key_input;
        for (int n = 0; n < 64; n++) if (h[n]) return n;
        return -1;
    endfunction
    task cmp_vec(vector_out_t e);
        total_checks++;
        if (vector_out.valid !== e.valid || e.valid && (vector_out !== e
            || fetch_hi !== e.address + 32'd3)) begin
            error_cnt++;
            $display("CHECK FAILED %0t vector %h", $time, vector_out);
        end
    endtask
    task cmp_reg(logic [31:0] got, logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t register %h", $time, got);
        end
    endtask
    // One request cycle, then the vector one edge later
    task go(periph_req_t r, logic ie, logic ir, logic break_instruction, logic [5:0] n);
        int num;
        vector_out_t e;
        num = ir ? (break_instruction ? 0 : n) : (ie ? ref_num(r, sel) : -1);
        @(posedge sys_clk);
        periph_req <= r;
        interrupt_enable <= ie;
        instr_req <= ir;
        instr_is_break <= break_instruction;
        instr_number <= n;
        @(posedge sys_clk);
        instr_req <= 0;
        periph_req <= '0;
        #1;
        e = {num >= 0, ir, num[5:0], base + {num[29:0], 2'b00}};
        cmp_vec(e);
    endtask
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && a == OFS_TABLE_BASE) base = d;
        if (w && a == OFS_SOURCE_SEL) sel = d[7:0];
    endtask
    initial begin
        void'($urandom(32'hf619));
        repeat (8) @(posedge sys_clk);
        rst <= 0;
        apb(0, OFS_TABLE_BASE, 0);
        cmp_reg(rd, TABLE_BASE_RESET);
        apb(0, OFS_SOURCE_SEL, 0);
        cmp_reg(rd, {24'h0, SOURCE_SEL_RESET});
        apb(0, 8'h10, 0);
        cmp_reg({rd[30:0], err}, 32'h0000_0001);
        $display("test registers done");
        // Odd base in odd rounds; every source bit alone, then pairs
        for (int t = 0; t < 4; t++) begin
            apb(1, OFS_TABLE_BASE, ($urandom() & 32'hFFFF_FFFE) | t[0]);
            apb(1, OFS_SOURCE_SEL, $urandom());
            apb(0, OFS_SOURCE_SEL, 0);
            cmp_reg(rd, {24'h0, sel});
            // The request struct is 43 bits wide; walk each line alone
            for (int b = 0; b < 43; b++)
                go(43'h1 << b, 1, 0, 0, 0);
            for (int k = 0; k < 20; k++)
                go((43'h1 << $urandom_range(42)) | (43'h1 << $urandom_range(
                    42)), 1'($urandom()), 0, 0, 0);
            for (int n = 0; n < 64; n++)
                go('1, 1'($urandom()), 1, n == 5, n);
            // Last vector was software number 63; number, source and address hold after it, valid clears
            apb(0, OFS_STATUS, 0);
            cmp_reg(rd, {21'h0, base[0], 2'b10, 2'h0, 6'h3F});
            apb(0, OFS_LAST_ADDR, 0);
            cmp_reg(rd, base + 32'd252);
            $display("test round %0d done", t);
        end
        conclude();
    end
endmodule

// File: verif/vector_fetch_model.sv
`timescale 1ns/1ps
module vector_fetch_model
    import vector_map_pkg::*;
(
    // Vector from the map
    input wire vector_out_t vector_out,
    // Highest byte address of the fetched entry
    output logic [31:0] fetch_hi
);
    // Entry is four bytes, low byte at the vector address
    assign fetch_hi = vector_out.address + 32'd3;
endmodule

// File: verif/vector_map_checker.sv
`timescale 1ns/1ps
module vector_map_checker
    import vector_map_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sources and vector
    input wire periph_req_t periph_req,
    input wire logic interrupt_enable,
    input wire logic instr_req,
    input wire logic instr_is_break,
    input wire logic [5:0] instr_number,
    input wire vector_out_t vector_out
);
    logic [31:0] base_q;
    // Shadow base, updated only where an APB write commits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            base_q <= 32'h0000_0000;
        else if (psel && penable && pwrite && paddr == OFS_TABLE_BASE)
            base_q <= pwdata;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_instr;
        instr_req;
    endsequence
    sequence s_instr_out;
        vector_out.valid && vector_out.from_instruction;
    endsequence
    a_instr_taken: assert property (s_instr |=> s_instr_out)
        else $error("instruction request not vectored");
    a_soft_number: assert property (instr_req && !instr_is_break
        |=> vector_out.number == $past(instr_number))
        else $error("software number wrong");
    a_break_zero: assert property (instr_req && instr_is_break
        |=> vector_out.number == NUM_BREAK)
        else $error("break number not zero");
    a_masked_quiet: assert property (!instr_req && !interrupt_enable
        |=> !vector_out.valid)
        else $error("masked request vectored");
    // Base is the one in force when the request was sampled
    a_addr_sum: assert property (vector_out.valid |->
        vector_out.address == $past(base_q) + {24'h0, vector_out.number, 2'b00})
        else $error("vector address not base plus offset");
    a_table_span: assert property (vector_out.valid |->
        vector_out.address - $past(base_q) < 32'd256)
        else $error("vector outside table");
    a_dma_lowest: assert property (!instr_req && interrupt_enable
        && periph_req.dma_done[0] |=> vector_out.number == NUM_DMA0)
        else $error("dma channel 0 number wrong");
    a_unmapped_err: assert property (psel && penable
        && paddr > OFS_LAST_ADDR |-> pslverr)
        else $error("unmapped access without error");
    a_ready_now: assert property (psel && penable |-> pready)
        else $error("access phase stalled");
endmodule
bind vector_address_map vector_map_checker chk (.sys_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .periph_req,
    .interrupt_enable, .instr_req, .instr_is_break, .instr_number,
    .vector_out);
